// ### hdl/fmt_pkg.sv
// constants shared by the result formatting block
package fmt_pkg;
  localparam int RAW_W = 20;
  localparam int FRAC_W = 3;
  localparam logic [1:0] LAYOUT_16 = 2'h0;
  localparam logic [1:0] LAYOUT_32_LEFT = 2'h1;
  localparam logic [1:0] LAYOUT_17_RIGHT = 2'h2;
  localparam logic [1:0] LAYOUT_17_TAG = 2'h3;
  localparam logic [1:0] LAYOUT_RESET = 2'h0;
  localparam logic [15:0] CLAMP16_POS = 16'h7FFF;
  localparam logic [15:0] CLAMP16_NEG = 16'h8000;
  localparam logic [16:0] CLAMP17_POS = 17'h0FFFF;
  localparam logic [16:0] CLAMP17_NEG = 17'h10000;
  localparam logic [3:0] TAG_NONE = 4'h0;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
  localparam logic [5:0] BITS_SHORT = 6'h10;
  localparam logic [5:0] BITS_LONG = 6'h20;
  localparam logic [7:0] RESULT_ADDR = 8'h00;
endpackage

// ### hdl/adc_result_format_por.sv
// result layout formatting, power-on reset and serial readout
// Notes on behaviour
// - four layouts picked by two-bit field: three 32-bit, one 16-bit.
// - upper field bit zero gives 16-bit two's complement, msb first.
// - 16-bit layouts clamp to 0x7FFF and 0x8000, no overrange.
// - layout 00 holds only the 16-bit signed value.
// - layout 01 left-justifies the code, low two bytes zero.
// - upper field bit one uses 17-bit code clamped 0x0FFFF/0x10000.
// - 17-bit code matches 16-bit code in normal range.
// - layout 10 right-justifies 17-bit code, upper bytes sign copies.
// - layout 11 puts channel tag in top four bits instead.
// - outside scan operation the channel tag reads 0000.
// - undervoltage on either supply holds reset, link off, defaults.
// - leave reset only once both supplies are good.
// - select rising edge returns serial logic to idle.
// - first select falling edge after reset clears reset interrupt.
// - in full shutdown supplies unmonitored, no reset event raised.
// - result register sits at address zero, 16 bits default.
// - filter result rounded to nearest step, not truncated.
`timescale 1ns/1ps
`default_nettype none
module adc_result_format_por #(
  parameter int RAW_W = fmt_pkg::RAW_W,
  parameter int FRAC_W = fmt_pkg::FRAC_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic avdd_good,
  input wire logic dvdd_good,
  input wire logic full_shutdown,
  input wire logic [1:0] layout_config_register,
  input wire logic scan_active,
  input wire logic [3:0] channel_tag,
  input wire logic [7:0] input_selector,
  input wire logic [RAW_W-1:0] filter_result,
  input wire logic filter_valid,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [7:0] cmd_addr,
  input wire logic cmd_read,
  output logic sdo,
  output logic sdo_oe,
  output logic por_irq_n,
  output logic in_reset,
  output logic [31:0] result_word,
  output logic [5:0] result_bits
);
  logic [2:0] av_s_q;
  logic [2:0] dv_s_q;
  logic supply_ok_q;
  logic live_rst_n;
  logic [1:0] layout_q;
  logic [RAW_W-1:0] rounded;
  logic [16:0] code17;
  logic [15:0] code16;
  logic [3:0] tag;
  logic [31:0] word_d;
  logic [31:0] word_q;
  logic [5:0] bits_d;
  logic [5:0] bits_q;
  logic in_reset_q;
  logic irq_n_q;
  logic [2:0] cs_s_q;
  logic cs_hi_seen_q;
  logic [31:0] shift_q;
  logic [5:0] cnt_q;
  logic sdo_q;
  logic oe_q;
  logic [2:0] tog_s_q;
  logic ack_tog_q;
  logic lnk_tog_q;
  logic [2:0] rst_lnk_q;
  logic settle_q;
  logic [1:0] lnk_bits;
  logic [1:0] lnk_s0_q;
  logic [1:0] lnk_s1_q;

  // clamp limits sign-extended to the raw width
  localparam logic [RAW_W-1:0] POS_LIM = RAW_W'(fmt_pkg::CLAMP17_POS);
  localparam logic [RAW_W-1:0] NEG_LIM =
    {{(RAW_W-17){fmt_pkg::CLAMP17_NEG[16]}}, fmt_pkg::CLAMP17_NEG};

  // a synced pin level counts once the last two flops agree
  function automatic logic settled(input logic [2:0] s);
    return s[1] == s[2];
  endfunction

  // bit count of a result read for a layout
  function automatic logic [5:0] layout_bits(input logic [1:0] sel);
    if (sel == fmt_pkg::LAYOUT_16)
      return fmt_pkg::BITS_SHORT;
    else
      return fmt_pkg::BITS_LONG;
  endfunction

  // short layout moved to the top of the shifter
  function automatic logic [31:0] load_word(input logic [31:0] w,
    input logic [5:0] n);
    if (n == fmt_pkg::BITS_SHORT)
      return {w[15:0], 16'h0000};
    else
      return w;
  endfunction

  // supply monitors pass three flip-flops, change counts when last two agree
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      av_s_q <= 3'h0;
      dv_s_q <= 3'h0;
      supply_ok_q <= 1'b0;
    end
    else
    begin
      av_s_q <= {av_s_q[1:0], avdd_good};
      dv_s_q <= {dv_s_q[1:0], dvdd_good};
      if (full_shutdown)
        supply_ok_q <= supply_ok_q;
      else if (settled(av_s_q) && settled(dv_s_q))
        supply_ok_q <= av_s_q[2] && dv_s_q[2];
    end
  end

  assign live_rst_n = resetn && supply_ok_q;

  // configuration held at default during reset
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      layout_q <= fmt_pkg::LAYOUT_RESET;
    else if (!supply_ok_q)
      layout_q <= fmt_pkg::LAYOUT_RESET;
    else
      layout_q <= layout_config_register;
  end

  // round to nearest then clamp
  always_comb
  begin
    rounded = filter_result + RAW_W'(1 << (FRAC_W - 1));
    if (!filter_result[RAW_W-1] && rounded[RAW_W-1])
      rounded = {1'b0, {(RAW_W-1){1'b1}}};
    rounded = rounded >>> FRAC_W;
    rounded = {{FRAC_W{rounded[RAW_W-1-FRAC_W]}},
      rounded[RAW_W-1-FRAC_W:0]};
    if ($signed(rounded) > $signed(POS_LIM))
      code17 = fmt_pkg::CLAMP17_POS;
    else if ($signed(rounded) < $signed(NEG_LIM))
      code17 = fmt_pkg::CLAMP17_NEG;
    else
      code17 = rounded[16:0];
    if (code17[16] != code17[15])
      code16 = code17[16] ? fmt_pkg::CLAMP16_NEG
        : fmt_pkg::CLAMP16_POS;
    else
      code16 = code17[15:0];
    tag = scan_active ? channel_tag : fmt_pkg::TAG_NONE;
  end

  // layout selection
  always_comb
  begin
    word_d = fmt_pkg::RESULT_RESET;
    bits_d = layout_bits(layout_q);
    case (layout_q)
      fmt_pkg::LAYOUT_16:
      begin
        word_d = {16'h0000, code16};
      end
      fmt_pkg::LAYOUT_32_LEFT:
        word_d = {code16, 16'h0000};
      fmt_pkg::LAYOUT_17_RIGHT:
        word_d = {{15{code17[16]}}, code17};
      default:
        word_d = {tag, {11{code17[16]}}, code17};
    endcase
  end

  // result register at address zero, cleared only by reset
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      word_q <= fmt_pkg::RESULT_RESET;
      bits_q <= fmt_pkg::BITS_SHORT;
      in_reset_q <= 1'b1;
      settle_q <= 1'b0;
    end
    else
    begin
      // hold reset flag one more cycle so outputs settle
      settle_q <= supply_ok_q;
      in_reset_q <= !supply_ok_q || !settle_q;
      if (!supply_ok_q)
      begin
        word_q <= fmt_pkg::RESULT_RESET;
        bits_q <= fmt_pkg::BITS_SHORT;
      end
      else
      begin
        bits_q <= bits_d;
        if (filter_valid)
          word_q <= word_d;
      end
    end
  end

  // reset interrupt, cleared on first select fall after reset
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cs_s_q <= 3'h7;
      cs_hi_seen_q <= 1'b0;
      irq_n_q <= 1'b0;
    end
    else
    begin
      cs_s_q <= {cs_s_q[1:0], cs_n};
      if (!supply_ok_q)
      begin
        cs_hi_seen_q <= 1'b0;
        irq_n_q <= 1'b0;
      end
      else if (settled(cs_s_q))
      begin
        if (cs_s_q[2])
          cs_hi_seen_q <= 1'b1;
        else if (cs_hi_seen_q)
          irq_n_q <= 1'b1;
      end
    end
  end

  // link enabled by first select rise after core reset ends
  always_ff @(posedge cs_n or negedge live_rst_n)
  begin
    if (!live_rst_n)
      rst_lnk_q <= 3'h0;
    else
      rst_lnk_q <= 3'h7;
  end

  // serial shifter on link clock, cs_n high forces idle
  always_ff @(negedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      cnt_q <= 6'h00;
      oe_q <= 1'b0;
      sdo_q <= 1'b0;
      shift_q <= fmt_pkg::RESULT_RESET;
      lnk_tog_q <= 1'b0;
    end
    else if (!rst_lnk_q[2])
    begin
      oe_q <= 1'b0;
      sdo_q <= 1'b0;
    end
    else if (cnt_q == 6'h00)
    begin
      if (cmd_read && cmd_addr == fmt_pkg::RESULT_ADDR)
      begin
        shift_q <= load_word(word_q,
          bits_q);
        cnt_q <= bits_q;
        oe_q <= 1'b1;
        lnk_tog_q <= !lnk_tog_q;
      end
    end
    else
    begin
      sdo_q <= shift_q[31];
      shift_q <= {shift_q[30:0], 1'b0};
      cnt_q <= cnt_q - 6'h01;
      // drive held until select rises
      oe_q <= 1'b1;
    end
  end

  assign lnk_bits = {oe_q, sdo_q};

  // link outputs resynced to core clock, two flops per bit
  for (genvar gi = 0; gi < 2; gi++)
  begin : g_lnk_sync
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
      begin
        lnk_s0_q[gi] <= 1'b0;
        lnk_s1_q[gi] <= 1'b0;
      end
      else
      begin
        lnk_s0_q[gi] <= lnk_bits[gi];
        lnk_s1_q[gi] <= lnk_s0_q[gi];
      end
    end
  end

  // read-event toggle crossing into core domain
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tog_s_q <= 3'h0;
      ack_tog_q <= 1'b0;
    end
    else
    begin
      tog_s_q <= {tog_s_q[1:0], lnk_tog_q};
      if (tog_s_q[1] == tog_s_q[2])
        ack_tog_q <= tog_s_q[2];
    end
  end

  // outputs
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      por_irq_n <= 1'b0;
      in_reset <= 1'b1;
      result_word <= fmt_pkg::RESULT_RESET;
      result_bits <= fmt_pkg::BITS_SHORT;
    end
    else
    begin
      sdo <= lnk_s1_q[0];
      sdo_oe <= lnk_s1_q[1] && !cs_s_q[2];
      por_irq_n <= irq_n_q;
      in_reset <= in_reset_q;
      result_word <= word_q;
      result_bits <= bits_q;
    end
  end
endmodule
`default_nettype wire

// ### test/fmt_checker.sv
// assertions on the result formatting block ports
`timescale 1ns/1ps
`default_nettype none
module fmt_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic avdd_good,
  input wire logic dvdd_good,
  input wire logic full_shutdown,
  input wire logic [1:0] layout_config_register,
  input wire logic scan_active,
  input wire logic filter_valid,
  input wire logic sdo_oe,
  input wire logic in_reset,
  input wire logic [31:0] result_word,
  input wire logic [5:0] result_bits
);
  wire [1:0] ly = layout_config_register;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_supply_loss_reset:
    assert property (($fell(avdd_good) || $fell(dvdd_good)) && !full_shutdown
      |-> ##[1:6] in_reset)
      else $error("no reset on supply loss");
  a_reset_link_off:
    assert property (in_reset |-> !sdo_oe) else $error("link driven in reset");
  a_reset_clears_word:
    assert property (in_reset && $past(in_reset) |-> result_word == 32'h0)
      else $error("result not cleared");
  a_release_both_good:
    assert property ($fell(in_reset) |-> $past(avdd_good, 3)
      && $past(dvdd_good, 3)) else $error("left reset too early");
  a_bits_follow_layout:
    assert property (!in_reset && $stable(ly)[*3] |->
      result_bits == (ly == 2'h0 ? 6'h10 : 6'h20)) else $error("bad bits");
  a_left_pad_zero:
    assert property ($past(filter_valid, 2) && ly == 2'h1 |->
      result_word[15:0] == 16'h0) else $error("low half not zero");
  a_sign_fill_bytes:
    assert property ($past(filter_valid, 2) && ly == 2'h2 |->
      result_word[31:16] == {16{result_word[16]}}) else $error("sign fill");
  a_tag_forced_zero:
    assert property ($past(filter_valid, 2) && ly == 2'h3 && !scan_active
      |-> result_word[31:28] == 4'h0) else $error("tag not zero");
endmodule
bind adc_result_format_por fmt_checker u_chk (.clk, .resetn, .avdd_good,
  .dvdd_good, .full_shutdown, .layout_config_register, .scan_active,
  .filter_valid, .sdo_oe, .in_reset, .result_word, .result_bits);
`default_nettype wire

// ### test/spi_host_model.sv
// host model reading results over the serial link
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic sck,
  output logic cs_n,
  output logic [7:0] cmd_addr,
  output logic cmd_read,
  input wire logic sdo
);
  initial
  begin
    sck = 1'h0;
    cs_n = 1'h0;
    cmd_addr = 8'hC3;
    cmd_read = 1'h0;
  end
  // select pulse first, then msb first sampling on rise
  task automatic read_word(input int n, output logic [31:0] w);
    w = 32'h0;
    cs_n = 1'h1;
    #64 cs_n = 1'h0;
    cmd_addr = 8'h00;
    cmd_read = 1'h1;
    #32 sck = 1'h1;
    #32 sck = 1'h0;
    for (int i = 0; i <= n; i++)
    begin
      #32 sck = 1'h1;
      if (i > 0)
        w = {w[30:0], sdo};
      if (i < n)
        #32 sck = 1'h0;
    end
    #32 cs_n = 1'h1;
    sck = 1'h0;
    cmd_read = 1'h0;
    cmd_addr = ~cmd_addr;
  endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the result formatting block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, resetn, avdd_good, dvdd_good, full_shutdown, scan_active;
  logic filter_valid, sdo, sdo_oe, por_irq_n, in_reset, sck, cs_n, cmd_read;
  logic [1:0] layout_config_register;
  logic [3:0] channel_tag;
  logic [7:0] input_selector, cmd_addr;
  logic [fmt_pkg::RAW_W-1:0] filter_result;
  logic [31:0] result_word, w, e;
  logic [5:0] result_bits;
  logic [19:0] corner [6] = '{20'h7FFFF, 20'h80000, 20'h3FFF8, 20'h40000,
    20'h00004, 20'hFFFFC};
  int err_count = 0;
  int compares = 0;
  adc_result_format_por u_dut (.clk, .resetn, .avdd_good, .dvdd_good,
    .full_shutdown, .layout_config_register, .scan_active, .channel_tag,
    .input_selector, .filter_result, .filter_valid, .sck, .cs_n, .cmd_addr,
    .cmd_read, .sdo, .sdo_oe, .por_irq_n, .in_reset, .result_word,
    .result_bits);
  spi_host_model u_host (.sck, .cs_n, .cmd_addr, .cmd_read, .sdo);
  function automatic logic [31:0] expect_word(logic [19:0] r,
    logic [1:0] l, logic [3:0] t);
    int v;
    logic [16:0] c;
    logic [15:0] h;
    v = (int'($signed(r)) + 4) >>> fmt_pkg::FRAC_W;
    c = v > 65535 ? fmt_pkg::CLAMP17_POS : v < -65536 ?
      fmt_pkg::CLAMP17_NEG : 17'(v);
    h = v > 32767 ? fmt_pkg::CLAMP16_POS : v < -32768 ?
      fmt_pkg::CLAMP16_NEG : 16'(v);
    case (l)
      2'h0: return {16'h0000, h};
      2'h1: return {h, 16'h0000};
      2'h2: return {{15{c[16]}}, c};
      default: return {t, {11{c[16]}}, c};
    endcase
  endfunction
  task automatic tally_and_finish;
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_ready;
    int k;
    k = 0;
    while (in_reset !== 1'h0 && k < 100)
    begin
      @(negedge clk);
      k++;
    end
    if (k == 100)
    begin
      err_count++;
      tally_and_finish;
    end
  endtask
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    {resetn, avdd_good, dvdd_good, full_shutdown, scan_active} = 5'h00;
    {filter_valid, layout_config_register, channel_tag} = 7'h00;
    input_selector = 8'h00;
    filter_result = '0;
    void'($urandom(32'h2F74));
    repeat (4) @(posedge clk);
    @(negedge clk) resetn = 1'h1;
    dvdd_good = 1'h1;
    repeat (20) @(negedge clk);
    check({31'h0, in_reset}, 32'h1);
    avdd_good = 1'h1;
    wait_ready;
    check({31'h0, por_irq_n}, 32'h0);
    for (int i = 0; i < 48; i++)
    begin
      filter_result = i < 6 ? corner[i] : 20'($urandom);
      layout_config_register = 2'(i);
      {scan_active, channel_tag, input_selector} = 13'($urandom);
      @(negedge clk) filter_valid = 1'h1;
      @(negedge clk) filter_valid = 1'h0;
      repeat (3) @(negedge clk);
      e = expect_word(filter_result, layout_config_register,
        scan_active ? channel_tag : fmt_pkg::TAG_NONE);
      check(result_word, e);
      check({26'h0, result_bits}, i % 4 == 0 ? 32'h10 : 32'h20);
      if (i % 5 == 0)
      begin
        u_host.read_word(i % 4 == 0 ? 16 : 32, w);
        @(negedge clk);
        check(w, e);
      end
    end
    check({31'h0, por_irq_n}, 32'h1);
    full_shutdown = 1'h1;
    repeat (8) @(negedge clk);
    avdd_good = 1'h0;
    repeat (20) @(negedge clk);
    check({31'h0, in_reset}, 32'h0);
    avdd_good = 1'h1;
    repeat (8) @(negedge clk);
    full_shutdown = 1'h0;
    dvdd_good = 1'h0;
    repeat (20) @(negedge clk);
    check({31'h0, in_reset}, 32'h1);
    check(result_word, fmt_pkg::RESULT_RESET);
    dvdd_good = 1'h1;
    wait_ready;
    tally_and_finish;
  end
endmodule
`default_nettype wire
